/* File: design/kms_scanner.sv */
/*
 key matrix scanner: walks eight active-low row drives, halts on a press,
 presents row code and columns to the processor bus and raises the
 keyboard interrupt with vector zero.
 assumes column inputs synchronous to clk, pulled high when no key is
 closed, and a processor that acknowledges with int_ack after reading.
*/
// Summary of operation
// - scan counter advances on time base while idle
// - three-bit binary row code, weights 1,2,4
// - decoder gives one row per code
// - selected row low, other seven high
// - only keys on driven row count
// - enabled press stops counter, freezes row code
// - pressed column low identifies key
// - row code and columns onto bidirectional bus
// - press sets interrupt flag, vector zero
`timescale 1ns/1ps
`default_nettype none
module kms_scanner (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    // key matrix
    output logic [kms_pkg::ROW_COUNT-1:0]          row_drive_n,
    input  wire logic [kms_pkg::COL_COUNT-1:0]     column_sense,
    // processor data bus, three-signal form
    input  wire logic                              bus_read,
    input  wire logic [7:0]                        bus_in,
    output logic [7:0]                             bus_out,
    output logic                                   bus_oe,
    // interrupt
    output logic                                   int_req,
    output logic                                   vector_zero_select,
    output logic [7:0]                             int_vector,
    input  wire logic                              int_ack,
    // status
    output logic [kms_pkg::ROW_BITS-1:0]           row_code,
    output logic                                   key_held
);
    kms_pkg::kms_state_type state;
    kms_pkg::kms_state_type next_state;
    kms_pkg::kms_key_type   key_latch;
    logic                   tick;
    logic [7:0]             bus_word;

    // ========================================================
    // time base
    kms_tick u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // ========================================================
    // decode helpers
    function automatic logic [kms_pkg::ROW_COUNT-1:0] row_select(
        input logic [kms_pkg::ROW_BITS-1:0] code);
        row_select = ~(kms_pkg::ROW_COUNT'(1) << code);
    endfunction

    // row drive and press detect, columns seen only for the driven row
    wire  [kms_pkg::ROW_COUNT-1:0] next_row_drive = row_select(row_code);
    wire  any_press = (column_sense != kms_pkg::COL_IDLE);
    wire  all_clear = (column_sense == kms_pkg::COL_IDLE);
    wire  in_scan   = (state == kms_pkg::KMS_SCAN);

    assign row_drive_n = next_row_drive;
    assign key_held    = (state != kms_pkg::KMS_SCAN);

    // ========================================================
    // scan state machine
    always_comb begin
        next_state = state;
        case (state)
            kms_pkg::KMS_SCAN: begin
                if (any_press) begin
                    next_state = kms_pkg::KMS_HELD;
                end
            end
            kms_pkg::KMS_HELD: begin
                if (all_clear) begin
                    next_state = kms_pkg::KMS_RELEASE;
                end
            end
            kms_pkg::KMS_RELEASE: begin
                next_state = any_press ? kms_pkg::KMS_HELD : kms_pkg::KMS_SCAN;
            end
            default: begin
                next_state = kms_pkg::KMS_SCAN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= kms_pkg::KMS_SCAN;
        end else begin
            state <= next_state;
        end
    end

    // scan counter, halts on a press
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            row_code <= kms_pkg::ROW_CODE_RESET;
        end else if (in_scan && !any_press && tick) begin
            row_code <= row_code + 1'b1;
        end
    end

    // key identity captured at the press
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_latch <= '{row_code: kms_pkg::ROW_CODE_RESET, column_sense: kms_pkg::COL_IDLE};
        end else if (in_scan && any_press) begin
            key_latch <= '{row_code: row_code, column_sense: column_sense};
        end
    end

    // ========================================================
    // data bus driver
    assign bus_word = {1'b0, key_latch};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_out <= 8'h00;
        end else begin
            bus_out <= bus_word;
        end
    end
    assign bus_oe = bus_read;

    // ========================================================
    // interrupt flag, a new press wins over acknowledge
    wire  int_set = in_scan && any_press;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_req <= 1'b0;
        end else if (int_set) begin
            int_req <= 1'b1;
        end else if (int_ack) begin
            int_req <= 1'b0;
        end
    end
    assign vector_zero_select = int_req;
    assign int_vector         = kms_pkg::KEY_VECTOR;

    // ========================================================
    // scan dwell counter, helper for the period check
    wire  scan_step = in_scan && !any_press && tick;
    logic [kms_pkg::DIV_BITS-1:0] dwell;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dwell <= '0;
        end else if (scan_step || !in_scan) begin
            dwell <= '0;
        end else if (dwell != '1) begin
            dwell <= dwell + 1'b1;
        end
    end

    // ========================================================
    // checks
    // scan walk and row decode
    chk_row_onehot: assert property (@(posedge clk) disable iff (!rst_n)
        $countones(~row_drive_n) == 1) else $error("row drive not one-hot low");
    chk_row_match: assert property (@(posedge clk) disable iff (!rst_n)
        !row_drive_n[row_code]) else $error("low row differs from row code");
    chk_scan_step: assert property (@(posedge clk) disable iff (!rst_n)
        (in_scan && !any_press && tick) |=> row_code == $past(row_code) + 3'h1)
        else $error("scan counter failed to step");
    chk_scan_period: assert property (@(posedge clk) disable iff (!rst_n)
        (in_scan && !any_press) |-> dwell < kms_pkg::DIV_BITS'(kms_pkg::SCAN_DIV))
        else $error("scan counter stood past one time base period");
    chk_no_tick_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !tick |=> $stable(row_code)) else $error("row code moved without tick");

    // press, hold and release
    chk_press_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        (any_press) |=> $stable(row_code)) else $error("press did not freeze scan");
    chk_held_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        key_held |=> $stable(row_code)) else $error("row code moved while halted");
    chk_no_relatch: assert property (@(posedge clk) disable iff (!rst_n)
        !in_scan |=> $stable(key_latch)) else $error("key identity changed while held");
    chk_press_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (in_scan && any_press) |=> key_held && int_req) else $error("press not latched");
    chk_key_id: assert property (@(posedge clk) disable iff (!rst_n)
        (in_scan && any_press) |=> key_latch.column_sense == $past(column_sense)
        && key_latch.row_code == $past(row_code)) else $error("key identity wrong");
    chk_held_stay: assert property (@(posedge clk) disable iff (!rst_n)
        (key_held && any_press) |=> key_held) else $error("scan resumed with key closed");
    chk_release_step: assert property (@(posedge clk) disable iff (!rst_n)
        (state == kms_pkg::KMS_RELEASE && any_press) |=> state == kms_pkg::KMS_HELD)
        else $error("second press after release not held");
    chk_resume: assert property (@(posedge clk) disable iff (!rst_n)
        (state == kms_pkg::KMS_HELD && all_clear) ##1 !any_press |=> in_scan)
        else $error("scan did not resume after release");

    // bus and interrupt
    chk_bus_drive: assert property (@(posedge clk) disable iff (!rst_n)
        bus_read |-> bus_oe) else $error("bus not driven on read");
    chk_bus_word: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(key_held) |=> bus_out == {1'b0, $past(row_code, 2), $past(column_sense, 2)})
        else $error("bus word differs from pressed key");
    chk_int_cause: assert property (@(posedge clk) disable iff (!rst_n)
        (!int_req && !int_set) |=> !int_req) else $error("interrupt raised without a press");
    chk_int_stands: assert property (@(posedge clk) disable iff (!rst_n)
        (int_req && !int_ack) |=> int_req) else $error("interrupt dropped before service");
    chk_ack_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (int_ack && !int_set) |=> !int_req) else $error("ack did not clear interrupt");

    // scenario covers
    cov_press: cover property (@(posedge clk) disable iff (!rst_n) in_scan && any_press);
    cov_release: cover property (@(posedge clk) disable iff (!rst_n)
        state == kms_pkg::KMS_RELEASE);
    cov_ack: cover property (@(posedge clk) disable iff (!rst_n) int_req ##1 int_ack);
    cov_wrap: cover property (@(posedge clk) disable iff (!rst_n) row_code == 3'h7 ##1 row_code == 3'h0);
    cov_read: cover property (@(posedge clk) disable iff (!rst_n) key_held && bus_read);
endmodule
`default_nettype wire

/* File: design/kms_pkg.sv */
/*
 package for the key matrix scanner: matrix sizes, time base figures,
 state encodings and the carrier struct shared by the scanner files.
 assumes a single 40 MHz system clock.
*/
package kms_pkg;
    // ========================================================
    // matrix geometry
    localparam int ROW_COUNT = 8;
    localparam int COL_COUNT = 4;
    localparam int ROW_BITS  = 3;

    // ========================================================
    // timing
    localparam int CLK_HZ       = 40_000_000;
    localparam int SCAN_BASE_HZ = 31_830;        // scan time base
    // longest period rounds down, never below one cycle
    localparam int SCAN_DIV_RAW = CLK_HZ / SCAN_BASE_HZ;
    localparam int SCAN_DIV     = (SCAN_DIV_RAW < 1) ? 1 : SCAN_DIV_RAW;
    localparam int DIV_BITS     = 11;

    // ========================================================
    // reset values and vector
    localparam logic [ROW_BITS-1:0]  ROW_CODE_RESET = 3'h0;
    localparam logic [COL_COUNT-1:0] COL_IDLE       = 4'hf;
    localparam logic [ROW_COUNT-1:0] ROW_IDLE       = 8'hff;
    localparam logic [7:0]           KEY_VECTOR     = 8'h00;

    // ========================================================
    // scanner states, gray along scan -> held -> wait release
    typedef enum logic [1:0] {
        KMS_SCAN    = 2'b00,
        KMS_HELD    = 2'b01,
        KMS_RELEASE = 2'b11
    } kms_state_type;

    // key identity as placed on the data bus
    typedef struct packed {
        logic [ROW_BITS-1:0]  row_code;
        logic [COL_COUNT-1:0] column_sense;
    } kms_key_type;
endpackage

/* File: design/kms_tick.sv */
/*
 holds the time base divider that makes a one-cycle scan enable.
 assumes the package constants for the clock rate and the divide ratio.
*/
`timescale 1ns/1ps
`default_nettype none
module kms_tick (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // scan time base enable
    output logic      tick
);
    logic [kms_pkg::DIV_BITS-1:0] count;
    wire                          at_end = (count == kms_pkg::DIV_BITS'(kms_pkg::SCAN_DIV - 1));

    // free-running divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (at_end) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    assign tick = at_end;

    chk_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick) else $error("scan tick lasted more than one cycle");
endmodule
`default_nettype wire

/* File: dv/kms_matrix.sv */
/*
 key matrix model: one key at a time, column lines pulled high.
 assumes active-low row drives from the scanner.
*/
`timescale 1ns/1ps
`default_nettype none
module kms_matrix (
    // row drives and key choice
    input  wire logic [7:0] row_drive_n,
    input  wire logic       press,
    input  wire logic [2:0] key_row,
    input  wire logic [1:0] key_col,
    // column lines
    output logic [3:0]      column_sense
);
    // ==========================================================
    // closed key pulls its column low only while its row is driven
    assign column_sense = (press && !row_drive_n[key_row]) ?
                          ~(4'h1 << key_col) : 4'hf;
endmodule
`default_nettype wire

/* File: dv/tb.sv */
/*
 scanner testbench: reset, scan walk, key presses with bus read and ack.
 assumes a 40 MHz clock and a scan step every 1256 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ==========================================================
    // signals
    logic       clk, rst_n, bus_read, int_ack, press, bus_oe;
    logic       int_req, vector_zero_select, key_held;
    logic [2:0] key_row, row_code;
    logic [1:0] key_col;
    logic [3:0] column_sense;
    logic [7:0] row_drive_n, bus_out, int_vector;
    int         n_fail = 0;
    int         check_count = 0;
    int         k;

    kms_scanner u_dut (.clk(clk), .rst_n(rst_n), .row_drive_n(row_drive_n),
        .column_sense(column_sense), .bus_read(bus_read), .bus_in(8'h00),
        .bus_out(bus_out), .bus_oe(bus_oe), .int_req(int_req),
        .vector_zero_select(vector_zero_select), .int_vector(int_vector),
        .int_ack(int_ack), .row_code(row_code), .key_held(key_held));
    kms_matrix u_keys (.row_drive_n(row_drive_n), .press(press), .key_row(key_row),
        .key_col(key_col), .column_sense(column_sense));

    // 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_code(input logic [2:0] c);
        for (k = 0; k < 12000 && row_code !== c; k++) @(negedge clk);
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic test_reset();
        chk({13'h0, row_code}, 16'h0000);
        chk({8'h00, row_drive_n}, 16'h00fe);
        chk({14'h0, int_req, key_held}, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_scan();
        logic [2:0] t;
        for (int i = 1; i <= 9; i++) begin
            t = i[2:0];
            wait_code(t);
            chk({13'h0, row_code}, {13'h0, t});
            chk({8'h00, row_drive_n}, {8'h00, ~(8'h01 << t)});
            if (i > 1) chk(k[15:0], 16'h04e8);
        end
        $display("test scan done");
    endtask

    task automatic test_press(input logic [2:0] r, input logic [1:0] c);
        key_row = r;
        key_col = c;
        press = 1'b1;
        for (k = 0; k < 12000 && key_held !== 1'b1; k++) @(negedge clk);
        chk({13'h0, row_code}, {13'h0, r});
        repeat (1300) @(negedge clk);
        chk({13'h0, row_code}, {13'h0, r});
        chk({14'h0, int_req, vector_zero_select}, 16'h0003);
        chk({8'h00, int_vector}, 16'h0000);
        bus_read = 1'b1;
        @(negedge clk);
        chk({7'h0, bus_oe, bus_out}, {8'h01, 1'b0, r, ~(4'h1 << c)});
        bus_read = 1'b0;
        int_ack = 1'b1;
        @(negedge clk);
        int_ack = 1'b0;
        @(negedge clk);
        chk({14'h0, bus_oe, int_req}, 16'h0000);
        press = 1'b0;
        repeat (3) @(negedge clk);
        chk({15'h0, key_held}, 16'h0000);
        wait_code(r + 3'h1);
        chk({13'h0, row_code}, {13'h0, r + 3'h1});
        $display("test press row %0d col %0d done", r, c);
    endtask

    // timeout guard
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        close_out();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        bus_read = 1'b0;
        int_ack = 1'b0;
        press = 1'b0;
        key_row = 3'h0;
        key_col = 2'h0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        test_reset();
        test_scan();
        test_press(3'h5, 2'h2);
        test_press(3'h0, 2'h0);
        test_press(3'h7, 2'h3);
        close_out();
    end
endmodule
`default_nettype wire
